//--- include/dcc_pkg.sv
// Constants and types for the downconverter configuration command interpreter
package dcc_pkg;
  localparam logic [7:0] ADDR_ACTIVITY   = 8'h02;
  localparam logic [7:0] ADDR_LOOP       = 8'h03;
  localparam logic [7:0] ADDR_IN_TUNE    = 8'h10;
  localparam logic [7:0] ADDR_OUT_TUNE   = 8'h11;
  localparam logic [7:0] ADDR_FRONT_AMP  = 8'h14;
  localparam logic [7:0] ADDR_ATTEN      = 8'h15;
  localparam logic [7:0] ADDR_ROUTING    = 8'h16;
  localparam logic [7:0] ADDR_GAIN_AUTO  = 8'h17;
  localparam logic [7:0] ADDR_SAVE       = 8'h18;
  localparam logic [7:0] ADDR_POWER      = 8'h19;
  localparam logic [7:0] ADDR_TIMEBASE   = 8'h1a;
  localparam logic [7:0] ADDR_TRIM       = 8'h1b;
  localparam logic [7:0] ADDR_OSC_ROUTE  = 8'h1c;
  localparam logic [7:0] ADDR_CALIBRATE  = 8'h1d;
  localparam logic [7:0] ADDR_NVM_WRITE  = 8'h1e;
  localparam logic [7:0] ADDR_PLAN       = 8'h1f;
  // Data byte counts per command
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_5 = 3'h5;
  localparam logic [2:0] LEN_7 = 3'h7;
  // Acknowledge byte value
  localparam logic [7:0] ACK_BYTE = 8'h00;
  // Field positions
  localparam int FREQ_W       = 48;
  localparam int DIRECT_LO1   = 48;
  localparam int PLAN_SEL_LO  = 48;
  localparam int PLAN_SEL_HI  = 50;
  localparam int ATTEN_SEL_LO = 8;
  localparam int ATTEN_SEL_HI = 10;
  localparam int SEC_LO       = 1;
  localparam int SEC_HI       = 3;
  localparam int LEVEL_IN_LO  = 8;
  localparam int LEVEL_MX_LO  = 16;
  localparam int LEVEL_OUT_LO = 24;
  localparam int NVM_ADDR_LO  = 8;
  localparam int NVM_ADDR_HI  = 23;
  localparam int TRIM_W       = 16;
  // Section codes
  localparam logic [2:0] SEC_ALL   = 3'h0;
  localparam logic [2:0] SEC_OSC1  = 3'h1;
  localparam logic [2:0] SEC_OSC2  = 3'h2;
  localparam logic [2:0] SEC_OSC3  = 3'h3;
  localparam logic [2:0] SEC_CHAIN = 3'h4;
  localparam int N_ATTEN = 6;

  typedef enum logic [2:0] {
    DCC_ADDR = 3'b001,
    DCC_DATA = 3'b010,
    DCC_ACK  = 3'b100
  } dcc_state_e;
endpackage

//--- design/dcc_top.sv
// Byte-wide configuration command interpreter of the downconverter
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        mclk,                // System clock
  input  wire logic        reset,               // Async reset, high
  input  wire logic [7:0]  rx_data,             // Incoming command byte
  input  wire logic        rx_valid,            // Byte present
  output logic             rx_ready,            // Byte accepted
  output logic [7:0]       ack_data,            // Acknowledge byte
  output logic             ack_valid,           // Acknowledge pending
  input  wire logic        ack_ready,           // Host reads acknowledge
  output logic             activity_led,        // Front-panel LED
  output logic [1:0]       loop_gain,           // Synth loop gain
  output logic             fast_tune,           // First oscillator fast tune
  output logic [47:0]      input_freq,          // Input frequency, mHz
  output logic [47:0]      output_freq,         // Final IF, mHz
  output logic [47:0]      lo1_direct_freq,     // Direct first LO word
  output logic             lo1_direct_load,     // Pulse: apply direct word
  output logic             tune_changed,        // Pulse: tuning changed
  output logic             input_amplifier_on,  // Input amplifier
  output logic [7:0]       atten_value [N_ATTEN], // Attenuators, 0.25 dB
  output logic             skip_all_mixing,     // Input to third-IF out
  output logic             external_second_if_select, // Ext second IF
  output logic             skip_third_mixing,   // Bypass third mixer
  output logic             second_if_filter_select, // 160/80 MHz
  output logic [1:0]       third_if_bank_one_select, // 500/250/thru
  output logic             third_if_bank_two_select, // LPF/bandpass
  output logic             spectrum_flip,       // Invert spectrum
  output logic             gain_automation_on,  // Auto gain enable
  output logic             computed_amplifier_control, // Auto amp
  output logic [1:0]       noise_linearity_tradeoff, // Trade-off code
  output logic [7:0]       expected_input_level, // Sign+magnitude dB
  output logic [7:0]       expected_mixer_level, // Sign+magnitude dB
  output logic [7:0]       expected_output_level, // Sign+magnitude dB
  output logic             gain_recompute,      // Pulse: recompute gain
  output logic             save_startup,        // Pulse: save settings
  output logic             standby_all,         // Whole device standby
  output logic [2:0]       standby_osc,         // Oscillators 1..3 standby
  output logic             standby_chain,       // Signal chain standby
  output logic             external_reference_lock, // Lock external ref
  output logic             reference_output_on, // Ref out enable
  output logic             reference_output_rate_select, // 10/100 MHz
  output logic             backplane_clock_export, // Backplane 10 MHz
  output logic [15:0]      trim_dac,            // Timebase DAC word
  output logic             lo1_external,        // First osc to out port
  output logic             calibrate_start,     // Pulse: start self-cal
  output logic             nvm_we,              // Pulse: memory write
  output logic [15:0]      nvm_addr,            // Memory address
  output logic [7:0]       nvm_wdata,           // Memory byte
  output logic             plan_we,             // Pulse: plan default
  output logic [2:0]       plan_sel,            // Plan frequency select
  output logic [47:0]      plan_value           // Plan default value
);

  typedef struct packed {
    dcc_state_e  state;
    logic [7:0]  addr;
    logic [2:0]  need;
    logic [2:0]  cnt;
    logic [55:0] shreg;
    logic        led;
    logic [1:0]  gain;
    logic        fast;
    logic [47:0] in_f;
    logic [47:0] out_f;
    logic [47:0] lo1_f;
    logic        lo1_ld;
    logic        tune_chg;
    logic [47:0] atten;
    logic [9:0]  route;
    logic [4:0]  auto;
    logic [23:0] levels;
    logic        recompute;
    logic        save;
    logic        sb_all;
    logic [2:0]  sb_osc;
    logic        sb_chain;
    logic [3:0]  tb;
    logic [15:0] trim;
    logic        lo1_ext;
    logic        cal;
    logic        nvm;
    logic [23:0] nvm_bits;
    logic        plan;
    logic [50:0] plan_bits;
  } dcc_state_s;

  dcc_state_s r;
  dcc_state_s next_r;

  function automatic logic [2:0] dcc_len(input logic [7:0] a);
    case (a)
      ADDR_IN_TUNE, ADDR_OUT_TUNE, ADDR_PLAN: dcc_len = LEN_7;
      ADDR_ATTEN, ADDR_ROUTING, ADDR_TRIM, ADDR_NVM_WRITE: dcc_len = LEN_3;
      ADDR_GAIN_AUTO: dcc_len = LEN_5;
      default: dcc_len = LEN_1;
    endcase
  endfunction

  logic [55:0] d;
  logic [2:0]  sel;

  always_comb begin
    next_r = r;
    next_r.lo1_ld = 1'b0;
    next_r.tune_chg = 1'b0;
    next_r.recompute = 1'b0;
    next_r.save = 1'b0;
    next_r.cal = 1'b0;
    next_r.nvm = 1'b0;
    next_r.plan = 1'b0;
    d = '0;
    sel = '0;
    case (r.state)
      DCC_ADDR: begin
        if (rx_valid) begin
          next_r.addr = rx_data;
          next_r.need = dcc_len(rx_data);
          next_r.cnt = '0;
          next_r.shreg = '0;
          next_r.state = DCC_DATA;
        end
      end
      DCC_DATA: begin
        if (rx_valid) begin
          // Data arrives least significant byte first
          d = {rx_data, r.shreg[55:8]} >> (8 * (3'h6 - r.cnt));
          next_r.shreg = {rx_data, r.shreg[55:8]};
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt + 3'h1 == r.need) begin
            next_r.state = DCC_ACK;
            case (r.addr)
              ADDR_ACTIVITY: next_r.led = d[0];
              ADDR_LOOP: begin
                next_r.gain = d[1:0];
                next_r.fast = d[2];
              end
              ADDR_IN_TUNE: begin
                if (d[DIRECT_LO1]) begin
                  next_r.lo1_f = d[FREQ_W-1:0];
                  next_r.lo1_ld = 1'b1;
                end else begin
                  next_r.in_f = d[FREQ_W-1:0];
                  next_r.tune_chg = 1'b1;
                  next_r.recompute = r.auto[0];
                end
              end
              ADDR_OUT_TUNE: begin
                next_r.out_f = d[FREQ_W-1:0];
                next_r.tune_chg = 1'b1;
                next_r.recompute = r.auto[0];
              end
              ADDR_FRONT_AMP: next_r.route[9] = d[0];
              ADDR_ATTEN: begin
                sel = d[ATTEN_SEL_HI:ATTEN_SEL_LO];
                if (sel < 3'(N_ATTEN) && sel != 3'h2)
                  next_r.atten[8*sel +: 8] = d[7:0];
              end
              ADDR_ROUTING: next_r.route = d[9:0];
              ADDR_GAIN_AUTO: begin
                next_r.auto = d[4:0];
                if (d[1])
                  next_r.levels = d[31:8];
              end
              ADDR_SAVE: next_r.save = 1'b1;
              ADDR_POWER: begin
                sel = d[SEC_HI:SEC_LO];
                case (sel)
                  SEC_ALL: next_r.sb_all = d[0];
                  SEC_OSC1: next_r.sb_osc[0] = d[0];
                  SEC_OSC2: next_r.sb_osc[1] = d[0];
                  SEC_OSC3: next_r.sb_osc[2] = d[0];
                  SEC_CHAIN: next_r.sb_chain = d[0];
                  default: next_r.sb_all = r.sb_all;
                endcase
              end
              ADDR_TIMEBASE: next_r.tb = d[3:0];
              ADDR_TRIM: next_r.trim = d[TRIM_W-1:0];
              ADDR_OSC_ROUTE: next_r.lo1_ext = d[0];
              ADDR_CALIBRATE: next_r.cal = 1'b1;
              ADDR_NVM_WRITE: begin
                next_r.nvm = 1'b1;
                next_r.nvm_bits = d[NVM_ADDR_HI:0];
              end
              ADDR_PLAN: begin
                next_r.plan = 1'b1;
                next_r.plan_bits = d[PLAN_SEL_HI:0];
              end
              default: next_r.addr = r.addr;
            endcase
          end
        end
      end
      DCC_ACK: begin
        if (ack_ready)
          next_r.state = DCC_ADDR;
      end
      default: next_r.state = DCC_ADDR;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.state <= DCC_ADDR;
    end else begin
      r <= next_r;
    end
  end

  assign rx_ready = (r.state != DCC_ACK);
  assign ack_valid = (r.state == DCC_ACK);
  assign ack_data = ACK_BYTE;
  assign activity_led = r.led;
  assign loop_gain = r.gain;
  assign fast_tune = r.fast;
  assign input_freq = r.in_f;
  assign output_freq = r.out_f;
  assign lo1_direct_freq = r.lo1_f;
  assign lo1_direct_load = r.lo1_ld;
  assign tune_changed = r.tune_chg;
  assign input_amplifier_on = r.route[9];
  for (genvar i = 0; i < N_ATTEN; i++) begin : g_att
    assign atten_value[i] = r.atten[8*i +: 8];
  end
  assign skip_all_mixing = r.route[0];
  assign external_second_if_select = r.route[1];
  assign skip_third_mixing = r.route[2];
  assign second_if_filter_select = r.route[4];
  assign third_if_bank_one_select = r.route[6:5];
  assign third_if_bank_two_select = r.route[7];
  assign spectrum_flip = r.route[8];
  assign gain_automation_on = r.auto[0];
  assign computed_amplifier_control = r.auto[2];
  assign noise_linearity_tradeoff = r.auto[4:3];
  assign expected_input_level = r.levels[7:0];
  assign expected_mixer_level = r.levels[15:8];
  assign expected_output_level = r.levels[23:16];
  assign gain_recompute = r.recompute;
  assign save_startup = r.save;
  assign standby_all = r.sb_all;
  assign standby_osc = r.sb_osc;
  assign standby_chain = r.sb_chain;
  assign external_reference_lock = r.tb[0];
  assign reference_output_on = r.tb[1];
  assign reference_output_rate_select = r.tb[2];
  assign backplane_clock_export = r.tb[3];
  assign trim_dac = r.trim;
  assign lo1_external = r.lo1_ext;
  assign calibrate_start = r.cal;
  assign nvm_we = r.nvm;
  assign nvm_addr = r.nvm_bits[NVM_ADDR_HI:NVM_ADDR_LO];
  assign nvm_wdata = r.nvm_bits[7:0];
  assign plan_we = r.plan;
  assign plan_sel = r.plan_bits[PLAN_SEL_HI:PLAN_SEL_LO];
  assign plan_value = r.plan_bits[FREQ_W-1:0];

  ack_after_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (r.state == DCC_DATA && rx_valid && next_r.state == DCC_ACK)
    |=> ack_valid) else $error("No acknowledge after last byte");
  no_rx_in_ack_a: assert property (@(posedge mclk) disable iff (reset)
    ack_valid && !ack_ready |=> ack_valid && !rx_ready)
    else $error("Ack dropped or byte taken before ack read");
  led_update_a: assert property (@(posedge mclk) disable iff (reset)
    (r.state == DCC_DATA && rx_valid && r.addr == ADDR_ACTIVITY)
    |=> activity_led == $past(rx_data[0])) else $error("LED wrong");
  loop_fast_a: assert property (@(posedge mclk) disable iff (reset)
    (r.state == DCC_DATA && rx_valid && r.addr == ADDR_LOOP)
    |=> fast_tune == $past(rx_data[2])) else $error("Fast tune wrong");
  direct_keep_a: assert property (@(posedge mclk) disable iff (reset)
    lo1_direct_load |-> $stable(input_freq))
    else $error("Input frequency changed on direct load");
  amp_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (r.state == DCC_DATA && rx_valid && r.addr == ADDR_FRONT_AMP)
    |=> input_amplifier_on == $past(rx_data[0])) else $error("Amp wrong");
  recompute_gate_a: assert property (@(posedge mclk) disable iff (reset)
    gain_recompute |-> tune_changed && gain_automation_on)
    else $error("Recompute without automation");
  cal_ack_a: assert property (@(posedge mclk) disable iff (reset)
    calibrate_start |-> ack_valid) else $error("Calibrate ack late");
  len_tune_a: assert property (@(posedge mclk) disable iff (reset)
    (r.state == DCC_ADDR && rx_valid && rx_data == ADDR_IN_TUNE)
    |=> (r.state == DCC_DATA && r.need == LEN_7))
    else $error("Tune length wrong");
endmodule

//--- verif/dcc_host_model.sv
// Host controller model that sends command bytes and reads acknowledges
`timescale 1ns/1ps
module dcc_host_model (
  input  wire logic       mclk,      // System clock
  output logic [7:0]      rx_data,   // Command byte
  output logic            rx_valid,  // Byte offered
  input  wire logic       rx_ready,  // Byte accepted
  input  wire logic       ack_valid, // Acknowledge pending
  output logic            ack_ready  // Acknowledge read
);
  logic [7:0] last_byte;
  int         hang;
  initial begin
    rx_data = 8'hff;
    rx_valid = 1'b0;
    ack_ready = 1'b0;
    last_byte = 8'h00;
    hang = 0;
  end
  // Address byte then exactly n data bytes, low byte first
  task automatic send_cmd(input logic [7:0] a, input logic [55:0] d,
                          input int n, input int gap);
    logic [7:0] b;
    int         k;
    for (int i = 0; i <= n; i++) begin
      b = (i == 0) ? a : d[8*(i-1) +: 8];
      if (gap > 0) begin
        rx_valid = 1'b0;
        rx_data = ~last_byte;
        repeat (gap) @(posedge mclk) #1;
      end
      rx_data = b;
      rx_valid = 1'b1;
      k = 0;
      while (rx_ready !== 1'b1 && k < 100) begin
        @(posedge mclk) #1;
        k++;
      end
      if (k == 100) hang++;
      @(posedge mclk) #1;
      last_byte = b;
    end
    rx_valid = 1'b0;
    rx_data = ~last_byte;
  endtask
  // The acknowledge is read before any further command
  task automatic read_ack(input int gap);
    int k;
    repeat (gap) @(posedge mclk) #1;
    k = 0;
    while (ack_valid !== 1'b1 && k < 100) begin
      @(posedge mclk) #1;
      k++;
    end
    if (k == 100) hang++;
    ack_ready = 1'b1;
    @(posedge mclk) #1;
    ack_ready = 1'b0;
  endtask
endmodule

//--- verif/dcc_tb_top.sv
// Self-checking bench for the configuration command interpreter
`timescale 1ns/1ps
module dcc_tb_top
  import dcc_pkg::*;
;
  logic        mclk, reset, rx_valid, rx_ready, ack_valid, ack_ready;
  logic [7:0]  rx_data, ack_data, nvm_wdata;
  logic        activity_led, fast_tune, lo1_direct_load, tune_changed;
  logic [1:0]  loop_gain, third_if_bank_one_select, noise_linearity_tradeoff;
  logic [47:0] input_freq, output_freq, lo1_direct_freq, plan_value;
  logic        input_amplifier_on, skip_all_mixing, external_second_if_select;
  logic        skip_third_mixing, second_if_filter_select, spectrum_flip;
  logic        third_if_bank_two_select, gain_automation_on, gain_recompute;
  logic        computed_amplifier_control, save_startup, standby_all;
  logic [7:0]  atten_value [N_ATTEN];
  logic [7:0]  expected_input_level, expected_mixer_level;
  logic [7:0]  expected_output_level;
  logic [2:0]  standby_osc, plan_sel;
  logic        standby_chain, external_reference_lock, reference_output_on;
  logic        reference_output_rate_select, backplane_clock_export;
  logic [15:0] trim_dac, nvm_addr;
  logic        lo1_external, calibrate_start, nvm_we, plan_we;
  logic [4:0]  pw_exp;
  logic [4:0]  pw_mask [6];
  logic [9:0]  route_val [2];
  int          err_total, cmp_count;

  dcc_top dut_u (
    .mclk(mclk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .ack_data(ack_data), .ack_valid(ack_valid),
    .ack_ready(ack_ready), .activity_led(activity_led),
    .loop_gain(loop_gain), .fast_tune(fast_tune), .input_freq(input_freq),
    .output_freq(output_freq), .lo1_direct_freq(lo1_direct_freq),
    .lo1_direct_load(lo1_direct_load), .tune_changed(tune_changed),
    .input_amplifier_on(input_amplifier_on), .atten_value(atten_value),
    .skip_all_mixing(skip_all_mixing),
    .external_second_if_select(external_second_if_select),
    .skip_third_mixing(skip_third_mixing),
    .second_if_filter_select(second_if_filter_select),
    .third_if_bank_one_select(third_if_bank_one_select),
    .third_if_bank_two_select(third_if_bank_two_select),
    .spectrum_flip(spectrum_flip), .gain_automation_on(gain_automation_on),
    .computed_amplifier_control(computed_amplifier_control),
    .noise_linearity_tradeoff(noise_linearity_tradeoff),
    .expected_input_level(expected_input_level),
    .expected_mixer_level(expected_mixer_level),
    .expected_output_level(expected_output_level),
    .gain_recompute(gain_recompute), .save_startup(save_startup),
    .standby_all(standby_all), .standby_osc(standby_osc),
    .standby_chain(standby_chain),
    .external_reference_lock(external_reference_lock),
    .reference_output_on(reference_output_on),
    .reference_output_rate_select(reference_output_rate_select),
    .backplane_clock_export(backplane_clock_export), .trim_dac(trim_dac),
    .lo1_external(lo1_external), .calibrate_start(calibrate_start),
    .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .plan_we(plan_we), .plan_sel(plan_sel), .plan_value(plan_value));
  dcc_host_model host_u (.mclk(mclk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .ack_valid(ack_valid), .ack_ready(ack_ready));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic test_done();
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A bounded wait that ran out ends the run as failed
  task automatic hang_chk();
    if (host_u.hang != 0) begin
      err_total++;
      test_done();
    end
  endtask

  // One command, ack checked in its first cycle with the expected pulses
  task automatic wr(input logic [7:0] a, input logic [55:0] d, input int n,
                    input logic [6:0] p);
    host_u.send_cmd(a, d, n, int'(a[0]));
    hang_chk();
    chk(ack_valid, 1'b1);
    chk(ack_data, ACK_BYTE);
    chk(rx_ready, 1'b0);
    chk({lo1_direct_load, tune_changed, gain_recompute, save_startup,
         calibrate_start, nvm_we, plan_we}, p);
    host_u.read_ack(int'(a[1:0]));
    hang_chk();
    chk(ack_valid, 1'b0);
  endtask

  initial begin
    reset = 1'b1;
    err_total = 0;
    cmp_count = 0;
    pw_mask = '{5'h10, 5'h02, 5'h04, 5'h08, 5'h01, 5'h00};
    route_val = '{10'h355, 10'h0ae};
    repeat (6) @(posedge mclk);
    #1 reset = 1'b0;
    chk({activity_led, input_freq}, 64'h0);
    chk(trim_dac, 16'h0000);
    chk(rx_ready, 1'b1);
    wr(ADDR_ACTIVITY, 56'h01, 1, 7'h00);
    chk(activity_led, 1'b1);
    wr(ADDR_ACTIVITY, 56'h00, 1, 7'h00);
    chk(activity_led, 1'b0);
    wr(ADDR_LOOP, 56'h06, 1, 7'h00);
    chk({loop_gain, fast_tune}, 3'b101);
    wr(ADDR_GAIN_AUTO, 56'h83_45_92_1d, 5, 7'h00);
    chk({gain_automation_on, computed_amplifier_control}, 2'b11);
    chk(noise_linearity_tradeoff, 2'h3);
    chk(expected_input_level, 8'h00);
    wr(ADDR_IN_TUNE, 56'h00_0123_4567_89ab, 7, 7'h30);
    chk(input_freq, 48'h0123_4567_89ab);
    wr(ADDR_IN_TUNE, 56'h01_fedc_ba98_7654, 7, 7'h40);
    chk(lo1_direct_freq, 48'hfedc_ba98_7654);
    chk(input_freq, 48'h0123_4567_89ab);
    wr(ADDR_GAIN_AUTO, 56'h83_45_92_0a, 5, 7'h00);
    chk({expected_output_level, expected_mixer_level,
         expected_input_level}, 24'h83_45_92);
    chk({gain_automation_on, computed_amplifier_control}, 2'b00);
    chk(noise_linearity_tradeoff, 2'h1);
    wr(ADDR_OUT_TUNE, 56'h00_0000_1dcd_6500, 7, 7'h20);
    chk(output_freq, 48'h0000_1dcd_6500);
    wr(ADDR_FRONT_AMP, 56'h01, 1, 7'h00);
    chk(input_amplifier_on, 1'b1);
    for (int i = 0; i < 8; i++)
      wr(ADDR_ATTEN, 56'(i) << 8 | 56'(8'h11 * i + 1), 3, 7'h00);
    for (int i = 0; i < N_ATTEN; i++)
      chk(atten_value[i], (i == 2) ? 8'h00 : 8'(8'h11 * i + 1));
    foreach (route_val[i]) begin
      wr(ADDR_ROUTING, 56'(route_val[i]), 3, 7'h00);
      chk({input_amplifier_on, spectrum_flip, third_if_bank_two_select,
           third_if_bank_one_select, second_if_filter_select,
           skip_third_mixing, external_second_if_select, skip_all_mixing},
          {route_val[i][9:4], route_val[i][2:0]});
    end
    wr(ADDR_SAVE, 56'h00, 1, 7'h08);
    pw_exp = 5'h00;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_POWER, 56'(i) << 1 | 56'h1, 1, 7'h00);
      pw_exp = pw_exp | pw_mask[i];
      chk({standby_all, standby_osc, standby_chain}, pw_exp);
    end
    wr(ADDR_POWER, 56'h02, 1, 7'h00);
    chk({standby_all, standby_osc, standby_chain}, 5'h1d);
    wr(ADDR_TIMEBASE, 56'h0d, 1, 7'h00);
    chk({backplane_clock_export, reference_output_rate_select,
         reference_output_on, external_reference_lock}, 4'hd);
    wr(ADDR_TRIM, 56'h00_a53c, 3, 7'h00);
    chk(trim_dac, 16'ha53c);
    wr(ADDR_OSC_ROUTE, 56'h01, 1, 7'h00);
    chk(lo1_external, 1'b1);
    wr(ADDR_OSC_ROUTE, 56'h00, 1, 7'h00);
    chk(lo1_external, 1'b0);
    wr(ADDR_CALIBRATE, 56'h00, 1, 7'h04);
    wr(ADDR_NVM_WRITE, 56'hbe_ef5a, 3, 7'h02);
    chk({nvm_addr, nvm_wdata}, 24'hbeef5a);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PLAN, 56'(i) << 48 | 56'h00_1234_5678_9a00 | 56'(i), 7,
         7'h01);
      chk({plan_sel, plan_value}, {3'(i), 48'h1234_5678_9a00 | 48'(i)});
    end
    wr(8'h40, 56'hff, 1, 7'h00);
    chk(activity_led, 1'b0);
    // A reset in mid-run clears every setting and frees the link
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    chk({trim_dac, nvm_addr}, 32'h0);
    chk(plan_value, 48'h0);
    chk({standby_all, standby_osc, standby_chain}, 5'h00);
    chk({rx_ready, ack_valid}, 2'b10);
    wr(ADDR_ACTIVITY, 56'h01, 1, 7'h00);
    chk(activity_led, 1'b1);
    test_done();
  end
endmodule
